// ### design/regbank_top.v
// Register bank with internal, external and alias registers on AXI4-Lite.
// Assumes one clock; external register logic answers in the strobe cycle.
//
// Functional notes
// - Each register is accessed whole, atomically, at one address.
// - Registers are 32 bits wide unless configured otherwise.
// - Register width is a power of two, at least eight bits.
// - Overlapping read-only and write-only fields: read returns one, write updates other.
// - No field bits exist above the register's top bit.
// - Shared address: reads hit read-only register, writes hit write-only register.
// - Unplaced fields pack without gaps from bit 0 or the top bit.
// - Internal registers keep all storage and access logic inside the bank.
// - External registers hold no flops; accesses forward to designer logic.
// - Alias and primary share one storage; changes visible everywhere.
// - Alias has its own decoded address but acts on primary storage.
// - Alias uses its own software access; hardware behaviour is the primary's.
// - Alias fields keep the primary's bit positions and sizes; with HIGH_FIRST set, the control alias maps bits [7:0], not the mode field.
// - Alias is as wide as the primary and may expose fewer fields.
// - Only read/write side effects and access rights may differ in an alias.
// - Alias takes the primary's implementation form, internal or external.
// - Software wins same-cycle contention unless a field gives hardware priority; hardware sets survive software clears.
`default_nettype none
`include "regbank_defs.vh"
module regbank_top #(
	parameter REG_W        = 32,
	parameter HIGH_FIRST   = 0,
	parameter LVL_HW_WINS  = 0
) (
	// Clock and reset
	input  wire              REF_CLK_I,
	input  wire              NRST_I,
	// AXI4-Lite write channels
	input  wire [11:0]       AWADDR_I,
	input  wire              AWVALID_I,
	output wire              AWREADY_O,
	input  wire [31:0]       WDATA_I,
	input  wire [3:0]        WSTRB_I,
	input  wire              WVALID_I,
	output wire              WREADY_O,
	output wire [1:0]        BRESP_O,
	output wire              BVALID_O,
	input  wire              BREADY_I,
	// AXI4-Lite read channels
	input  wire [11:0]       ARADDR_I,
	input  wire              ARVALID_I,
	output wire              ARREADY_O,
	output wire [31:0]       RDATA_O,
	output wire [1:0]        RRESP_O,
	output wire              RVALID_O,
	input  wire              RREADY_I,
	// Hardware fields
	output wire [REG_W-1:0]  CTRL_O,
	input  wire              LVL_HW_WE_I,
	input  wire [7:0]        LVL_HW_I,
	input  wire [7:0]        EVT_SET_I,
	output wire [7:0]        EVT_O,
	input  wire [15:0]       STAT_I,
	output reg  [15:0]       CMD_O,
	output reg               CMD_STB_O,
	output reg  [15:0]       WO_FIELD_O,
	// External register port
	output reg               EXT_WR_O,
	output reg               EXT_RD_O,
	output reg  [5:0]        EXT_IDX_O,
	output reg  [REG_W-1:0]  EXT_WDATA_O,
	output reg               EXT_ALIAS_O,
	input  wire [REG_W-1:0]  EXT_RDATA_I,
	input  wire              EXT_ERR_I
);
	// Width check for power of two, at least eight bits
	localparam W_OK = (REG_W >= 8) && ((REG_W & (REG_W - 1)) == 0);
	// Default layout packs mode then level, end to end
	localparam MODE_LSB = HIGH_FIRST ? REG_W - `CTRL_MODE_W : `CTRL_MODE_LSB;
	localparam LVL_LSB  = HIGH_FIRST ? MODE_LSB - `CTRL_LVL_W : `CTRL_LVL_LSB;
	localparam [31:0] CTRL_RST_V = `CTRL_RST;

	wire             wr_stb;
	wire [11:0]      wr_addr;
	wire [31:0]      wr_data;
	wire [3:0]       wr_be;
	wire             rd_stb;
	wire [11:0]      rd_addr;
	reg  [31:0]      rd_data;
	reg              rd_err;
	reg              wr_err;
	wire [7:0]       mode_q;
	wire [7:0]       lvl_q;
	wire [7:0]       evt_q;
	reg  [REG_W-1:0] wmask;
	reg  [REG_W-1:0] wr_full;
	reg  [REG_W-1:0] ctrl_img;
	reg  [REG_W-1:0] rd_full;

	axil_slave_port #(
		.AW(12)
	) u_bus (
		.clk_i     (REF_CLK_I),
		.nrst_i    (NRST_I),
		.awaddr_i  (AWADDR_I),
		.awvalid_i (AWVALID_I),
		.awready_o (AWREADY_O),
		.wdata_i   (WDATA_I),
		.wstrb_i   (WSTRB_I),
		.wvalid_i  (WVALID_I),
		.wready_o  (WREADY_O),
		.bresp_o   (BRESP_O),
		.bvalid_o  (BVALID_O),
		.bready_i  (BREADY_I),
		.araddr_i  (ARADDR_I),
		.arvalid_i (ARVALID_I),
		.arready_o (ARREADY_O),
		.rdata_o   (RDATA_O),
		.rresp_o   (RRESP_O),
		.rvalid_o  (RVALID_O),
		.rready_i  (RREADY_I),
		.wr_stb_o  (wr_stb),
		.wr_addr_o (wr_addr),
		.wr_data_o (wr_data),
		.wr_be_o   (wr_be),
		.wr_err_i  (wr_err),
		.rd_stb_o  (rd_stb),
		.rd_addr_o (rd_addr),
		.rd_data_i (rd_data),
		.rd_err_i  (rd_err)
	);

	// Byte strobes widen to a bit mask; register sits in low bits of the word
	genvar gi;
	generate
		for (gi = 0; gi < REG_W; gi = gi + 1) begin : g_mask
			always @* begin
				wmask[gi]   = (gi < 32) ? wr_be[(gi % 32) / 8] : 1'b0;
				wr_full[gi] = (gi < 32) ? wr_data[gi % 32] : 1'b0;
			end
		end
	endgenerate

	// Decoded write strobes for the control and event addresses and their aliases
	wire wr_ctrl   = wr_stb && (wr_addr == `OFS_CTRL);
	wire wr_ctrl_a = wr_stb && (wr_addr == `OFS_CTRL_ALIAS);
	wire wr_evt    = wr_stb && (wr_addr == `OFS_EVT);
	wire wr_evt_a  = wr_stb && (wr_addr == `OFS_EVT_ALIAS);
	wire ar_take   = ARVALID_I && ARREADY_O; // Read address taken at this edge
	// Whole-register masked update, merged per byte lane in one access
	wire [REG_W-1:0] ctrl_wval  = (ctrl_img & ~wmask) | (wr_full & wmask);
	// Alias touches only exposed bits, other bits keep their stored value
	wire [REG_W-1:0] alias_m    = wmask & `CTRL_ALIAS_MASK;
	wire [REG_W-1:0] ctrl_awval = (ctrl_img & ~alias_m) | (wr_full & alias_m);
	wire [REG_W-1:0] ctrl_nv    = wr_ctrl_a ? ctrl_awval : ctrl_wval;

	// Mode field: primary read/write, alias read/write at same position only when HIGH_FIRST is 0
	sw_field #(
		.W       (`CTRL_MODE_W),
		.HW_WINS (0),
		.RST     (CTRL_RST_V[`CTRL_MODE_LSB +: `CTRL_MODE_W])
	) u_mode (
		.clk_i         (REF_CLK_I),
		.nrst_i        (NRST_I),
		.sw_wr_i       (wr_ctrl | wr_ctrl_a),
		.sw_wdata_i    (ctrl_nv[MODE_LSB +: `CTRL_MODE_W]),
		.sw_w1c_i      (1'b0),
		.sw_w1c_mask_i (8'h00),
		.sw_w1s_i      (1'b0),
		.sw_w1s_mask_i (8'h00),
		.sw_rclr_i     (1'b0),
		.hw_we_i       (1'b0),
		.hw_data_i     (8'h00),
		.hw_set_i      (8'h00),
		.q_o           (mode_q)
	);

	// Level field: software and hardware writable, not exposed by alias
	sw_field #(
		.W       (`CTRL_LVL_W),
		.HW_WINS (LVL_HW_WINS),
		.RST     (CTRL_RST_V[`CTRL_LVL_LSB +: `CTRL_LVL_W])
	) u_lvl (
		.clk_i         (REF_CLK_I),
		.nrst_i        (NRST_I),
		.sw_wr_i       (wr_ctrl),
		.sw_wdata_i    (ctrl_nv[LVL_LSB +: `CTRL_LVL_W]),
		.sw_w1c_i      (1'b0),
		.sw_w1c_mask_i (8'h00),
		.sw_w1s_i      (1'b0),
		.sw_w1s_mask_i (8'h00),
		.sw_rclr_i     (1'b0),
		.hw_we_i       (LVL_HW_WE_I),
		.hw_data_i     (LVL_HW_I),
		.hw_set_i      (8'h00),
		.q_o           (lvl_q)
	);

	// Event field: primary clears by write-one, alias sets by write-one, alias reads clear
	sw_field #(
		.W       (`EVT_W),
		.HW_WINS (0),
		.RST     (`EVT_RST)
	) u_evt (
		.clk_i         (REF_CLK_I),
		.nrst_i        (NRST_I),
		.sw_wr_i       (1'b0),
		.sw_wdata_i    (8'h00),
		.sw_w1c_i      (wr_evt && wr_be[0]),
		.sw_w1c_mask_i (wr_data[7:0]),
		.sw_w1s_i      (wr_evt_a && wr_be[0]),
		.sw_w1s_mask_i (wr_data[7:0]),
		.sw_rclr_i     (rd_stb && (rd_addr == `OFS_EVT_ALIAS)),
		.hw_we_i       (1'b0),
		.hw_data_i     (8'h00),
		.hw_set_i      (EVT_SET_I),
		.q_o           (evt_q)
	);

	// Image of the control register; bits above fields are not built
	always @* begin
		ctrl_img = {REG_W{1'b0}};
		ctrl_img[MODE_LSB +: `CTRL_MODE_W] = mode_q;
		ctrl_img[LVL_LSB +: `CTRL_LVL_W]   = lvl_q;
	end

	assign CTRL_O = ctrl_img;
	assign EVT_O  = evt_q;

	// Read mux; alias views hide unexposed bits, shared write-only addresses read STAT_I
	always @* begin
		rd_full = {REG_W{1'b0}};
		rd_err  = 1'b0;
		case (rd_addr)
			`OFS_CTRL:       rd_full = ctrl_img;
			`OFS_CTRL_ALIAS: rd_full = ctrl_img & `CTRL_ALIAS_MASK;
			`OFS_EVT:        rd_full = {{(REG_W-8){1'b0}}, evt_q};
			`OFS_EVT_ALIAS:  rd_full = {{(REG_W-8){1'b0}}, evt_q};
			`OFS_STAT:       rd_full = {{(REG_W-16){1'b0}}, STAT_I};
			`OFS_RO_WO:      rd_full = {{(REG_W-16){1'b0}}, STAT_I};
			default: begin
				if (rd_addr[11:8] == `OFS_EXT_BASE >> 8 ||
				    rd_addr[11:8] == `OFS_EXT_ALIAS >> 8) begin
					rd_full = EXT_RDATA_I;
					rd_err  = EXT_ERR_I;
				end else
					rd_err  = 1'b1;
			end
		endcase
		rd_data = rd_full[31:0];
		if (!W_OK)
			rd_err = 1'b1;
	end

	// Write decode error for unmapped addresses
	always @* begin
		case (wr_addr)
			`OFS_CTRL,
			`OFS_CTRL_ALIAS,
			`OFS_EVT,
			`OFS_EVT_ALIAS,
			`OFS_CMD,
			`OFS_RO_WO: wr_err = 1'b0;
			default: begin
				if (wr_addr[11:8] == `OFS_EXT_BASE >> 8 ||
				    wr_addr[11:8] == `OFS_EXT_ALIAS >> 8)
					wr_err = EXT_ERR_I;
				else
					wr_err = 1'b1;
			end
		endcase
	end

	// Write-only command, write-only overlay field, external forwarding
	always @(posedge REF_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			CMD_O       <= 16'h0000;
			CMD_STB_O   <= 1'b0;
			WO_FIELD_O  <= `WO_RST;
			EXT_WR_O    <= 1'b0;
			EXT_RD_O    <= 1'b0;
			EXT_IDX_O   <= 6'h00;
			EXT_WDATA_O <= {REG_W{1'b0}};
			EXT_ALIAS_O <= 1'b0;
		end else begin
			CMD_STB_O <= wr_stb && (wr_addr == `OFS_CMD);
			if (wr_stb && (wr_addr == `OFS_CMD))
				CMD_O <= wr_data[15:0];
			if (wr_stb && (wr_addr == `OFS_RO_WO))
				WO_FIELD_O <= wr_data[15:0];
			EXT_WR_O <= wr_stb && (wr_addr[11:8] == `OFS_EXT_BASE >> 8 ||
				wr_addr[11:8] == `OFS_EXT_ALIAS >> 8);
			// Read index stands from the address take, so it is valid in the
			// strobe cycle in which the external read data are sampled
			EXT_RD_O <= ar_take && (ARADDR_I[11:8] == `OFS_EXT_BASE >> 8 ||
				ARADDR_I[11:8] == `OFS_EXT_ALIAS >> 8);
			if (wr_stb)
				EXT_WDATA_O <= wr_full;
			// Window reads and writes must not overlap: a read take steers the index
			if (ar_take) begin
				EXT_IDX_O   <= ARADDR_I[7:2];
				EXT_ALIAS_O <= (ARADDR_I[11:8] == `OFS_EXT_ALIAS >> 8);
			end else if (wr_stb) begin
				EXT_IDX_O   <= wr_addr[7:2];
				EXT_ALIAS_O <= (wr_addr[11:8] == `OFS_EXT_ALIAS >> 8);
			end
		end
	end

endmodule
`default_nettype wire

// ### shared/regbank_defs.vh
// Offsets, field layouts and reset values of the register bank.
// Included once by the bank top and bus front-end design files; defines only.
`ifndef REGBANK_DEFS_VH
`define REGBANK_DEFS_VH
// Byte offsets
`define OFS_CTRL        12'h000
`define OFS_CTRL_ALIAS  12'h004
`define OFS_EVT         12'h008
`define OFS_EVT_ALIAS   12'h00c
`define OFS_STAT        12'h010
`define OFS_CMD         12'h010
`define OFS_RO_WO       12'h014
`define OFS_EXT_BASE    12'h100
`define OFS_EXT_ALIAS   12'h200
// Field layouts (low_first_bit_order packing of [7:0] mode, [15:8] level)
`define CTRL_MODE_LSB   0
`define CTRL_MODE_W     8
`define CTRL_LVL_LSB    8
`define CTRL_LVL_W      8
`define CTRL_ALIAS_MASK 32'h000000ff
`define EVT_W           8
// Reset values
`define CTRL_RST        32'h00000000
`define EVT_RST         8'h00
`define WO_RST          16'h0000
// Bus responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`endif

// ### design/axil_slave_port.v
// AXI4-Lite slave front end: takes one write and one read at a time.
// Assumes the register bank answers a strobe in the same cycle.
`default_nettype none
`include "regbank_defs.vh"
module axil_slave_port #(
	parameter AW = 12
) (
	// Clock and reset
	input  wire          clk_i,
	input  wire          nrst_i,
	// Write channels
	input  wire [AW-1:0] awaddr_i,
	input  wire          awvalid_i,
	output reg           awready_o,
	input  wire [31:0]   wdata_i,
	input  wire [3:0]    wstrb_i,
	input  wire          wvalid_i,
	output reg           wready_o,
	output reg  [1:0]    bresp_o,
	output reg           bvalid_o,
	input  wire          bready_i,
	// Read channels
	input  wire [AW-1:0] araddr_i,
	input  wire          arvalid_i,
	output reg           arready_o,
	output reg  [31:0]   rdata_o,
	output reg  [1:0]    rresp_o,
	output reg           rvalid_o,
	input  wire          rready_i,
	// Bank side
	output reg           wr_stb_o,
	output reg  [AW-1:0] wr_addr_o,
	output reg  [31:0]   wr_data_o,
	output reg  [3:0]    wr_be_o,
	input  wire          wr_err_i,
	output reg           rd_stb_o,
	output reg  [AW-1:0] rd_addr_o,
	input  wire [31:0]   rd_data_i,
	input  wire          rd_err_i
);
	reg aw_have_ff;
	reg w_have_ff;

	// Write path: catch address and data in either order, then strobe once
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			awready_o  <= 1'b1;
			wready_o   <= 1'b1;
			aw_have_ff <= 1'b0;
			w_have_ff  <= 1'b0;
			wr_stb_o   <= 1'b0;
			wr_addr_o  <= {AW{1'b0}};
			wr_data_o  <= 32'h00000000;
			wr_be_o    <= 4'h0;
			bvalid_o   <= 1'b0;
			bresp_o    <= `RESP_OKAY;
		end else begin
			wr_stb_o <= 1'b0;
			if (awvalid_i && awready_o) begin
				wr_addr_o  <= awaddr_i;
				aw_have_ff <= 1'b1;
				awready_o  <= 1'b0;
			end
			if (wvalid_i && wready_o) begin
				wr_data_o <= wdata_i;
				wr_be_o   <= wstrb_i;
				w_have_ff <= 1'b1;
				wready_o  <= 1'b0;
			end
			if (aw_have_ff && w_have_ff && !wr_stb_o && !bvalid_o) begin
				wr_stb_o   <= 1'b1;
				aw_have_ff <= 1'b0;
				w_have_ff  <= 1'b0;
			end
			if (wr_stb_o) begin
				bvalid_o <= 1'b1;
				bresp_o  <= wr_err_i ? `RESP_SLVERR : `RESP_OKAY;
			end
			if (bvalid_o && bready_i) begin
				bvalid_o  <= 1'b0;
				awready_o <= 1'b1;
				wready_o  <= 1'b1;
			end
		end
	end

	// Read path: one strobe per accepted address, data registered
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			arready_o  <= 1'b1;
			rd_stb_o   <= 1'b0;
			rd_addr_o  <= {AW{1'b0}};
			rvalid_o   <= 1'b0;
			rdata_o    <= 32'h00000000;
			rresp_o    <= `RESP_OKAY;
		end else begin
			rd_stb_o <= 1'b0;
			if (arvalid_i && arready_o) begin
				rd_addr_o  <= araddr_i;
				rd_stb_o   <= 1'b1;
				arready_o  <= 1'b0;
			end
			if (rd_stb_o) begin
				rvalid_o   <= 1'b1;
				rdata_o    <= rd_data_i;
				rresp_o    <= rd_err_i ? `RESP_SLVERR : `RESP_OKAY;
			end
			if (rvalid_o && rready_i) begin
				rvalid_o  <= 1'b0;
				arready_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ### design/sw_field.v
// One software/hardware field of width W with primary and alias access.
// Write strobes come from the bank decode; hardware inputs are synchronous.
`default_nettype none
module sw_field #(
	parameter W        = 8,
	parameter HW_WINS  = 0,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         nrst_i,
	// Software side
	input  wire         sw_wr_i,
	input  wire [W-1:0] sw_wdata_i,
	input  wire         sw_w1c_i,
	input  wire [W-1:0] sw_w1c_mask_i,
	input  wire         sw_w1s_i,
	input  wire [W-1:0] sw_w1s_mask_i,
	input  wire         sw_rclr_i,
	// Hardware side
	input  wire         hw_we_i,
	input  wire [W-1:0] hw_data_i,
	input  wire [W-1:0] hw_set_i,
	// Stored value
	output reg  [W-1:0] q_o
);
	reg         sw_act;
	reg         hw_act;
	reg [W-1:0] sw_val;
	reg [W-1:0] hw_val;
	reg [W-1:0] nxt_q;

	// Software and hardware candidate values, then precedence
	always @* begin
		sw_val = q_o;
		if (sw_wr_i)
			sw_val = sw_wdata_i;
		if (sw_w1c_i)
			sw_val = q_o & ~sw_w1c_mask_i;
		if (sw_w1s_i)
			sw_val = q_o | sw_w1s_mask_i;
		if (sw_rclr_i)
			sw_val = {W{1'b0}};
		sw_act = sw_wr_i | sw_w1c_i | sw_w1s_i | sw_rclr_i;
		hw_val = (hw_we_i ? hw_data_i : q_o) | hw_set_i;
		hw_act = hw_we_i | (|hw_set_i);
		nxt_q  = q_o;
		if (HW_WINS != 0) begin
			if (hw_act)
				nxt_q = hw_val;
			else if (sw_act)
				nxt_q = sw_val;
		end else begin
			if (sw_act)
				nxt_q = sw_val | (sw_rclr_i | sw_w1c_i | sw_w1s_i ? hw_set_i : {W{1'b0}});
			else if (hw_act)
				nxt_q = hw_val;
		end
	end

	// Single physical storage shared by every address that reaches it
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			q_o <= RST;
		else
			q_o <= nxt_q;
	end
endmodule
`default_nettype wire

// ### test/ext_reg_model.sv
// Model of the designer logic behind the external register window.
// Assumes the bank samples read data while the word index is held.
`default_nettype none
module ext_reg_model (
	// Clock
	input  wire logic        clk_i,
	// Bank side
	input  wire logic        wr_i,
	input  wire logic [5:0]  idx_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        fail_i,
	output logic      [31:0] rdata_o,
	output logic             err_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem_ff [64];
	// Storage lives here, not in the bank
	always @(posedge clk_i) begin
		if (wr_i) begin
			mem_ff[idx_i] <= wdata_i;
		end
	end
	// Read answer, error only when the bench asks for one
	assign rdata_o = mem_ff[idx_i];
	assign err_o   = fail_i;
endmodule
`default_nettype wire

// ### test/regbank_sva.sv
// Checker on the bank's top ports: bus timing and field updates.
// Assumes address and data of a write are offered together.
`default_nettype none
module regbank_sva #(
	parameter REG_W = 32
) (
	// Clock, reset and bus
	input wire logic             REF_CLK_I,
	input wire logic             NRST_I,
	input wire logic             AWVALID_I,
	input wire logic             AWREADY_O,
	input wire logic             WVALID_I,
	input wire logic             WREADY_O,
	input wire logic             BVALID_O,
	input wire logic             ARVALID_I,
	input wire logic             ARREADY_O,
	input wire logic             RVALID_O,
	// Fields
	input wire logic [REG_W-1:0] CTRL_O,
	input wire logic             LVL_HW_WE_I,
	input wire logic [7:0]       LVL_HW_I,
	input wire logic [7:0]       EVT_SET_I,
	input wire logic [7:0]       EVT_O,
	input wire logic             CMD_STB_O,
	input wire logic             EXT_WR_O
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!NRST_I);
	// Handshake steps of a write and a read
	sequence s_wr_take;
		AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
	endsequence
	sequence s_rd_take;
		ARVALID_I && ARREADY_O;
	endsequence
	a_write_latency: assert property (s_wr_take |-> ##[2:3] BVALID_O)
		else $error("write response missing");
	a_read_latency: assert property (s_rd_take |-> ##2 RVALID_O)
		else $error("read response missing");
	a_aw_busy: assert property (s_wr_take |=> !AWREADY_O ##1 !AWREADY_O)
		else $error("write accepted while busy");
	a_ar_busy: assert property (s_rd_take |=> !ARREADY_O ##1 !ARREADY_O)
		else $error("read accepted while busy");
	a_cmd_pulse: assert property (CMD_STB_O |-> !AWREADY_O ##1 !CMD_STB_O)
		else $error("command strobe bad");
	a_ext_pulse: assert property (EXT_WR_O |=> !EXT_WR_O)
		else $error("external write strobe too long");
	a_evt_set_wins: assert property (EVT_SET_I != 8'h00 |=>
		(EVT_O & $past(EVT_SET_I)) == $past(EVT_SET_I))
		else $error("event set lost");
	a_ctrl_cause: assert property ($changed(CTRL_O) |->
		!AWREADY_O || $past(LVL_HW_WE_I))
		else $error("control changed without cause");
	a_level_hw: assert property (LVL_HW_WE_I && AWREADY_O |=>
		CTRL_O[15:8] == $past(LVL_HW_I))
		else $error("hardware level write lost");
endmodule
bind regbank_top regbank_sva #(.REG_W(REG_W)) u_sva (.REF_CLK_I, .NRST_I, .AWVALID_I,
	.AWREADY_O, .WVALID_I, .WREADY_O, .BVALID_O, .ARVALID_I, .ARREADY_O, .RVALID_O,
	.CTRL_O, .LVL_HW_WE_I, .LVL_HW_I, .EVT_SET_I, .EVT_O, .CMD_STB_O, .EXT_WR_O);
`default_nettype wire

// ### test/register_bank_with_aliases_test.sv
// Testbench for the register bank: table of bus accesses, then hand tests.
// Assumes the external window is served by ext_reg_model.
`default_nettype none
module register_bank_with_aliases_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic w; logic [11:0] a; logic [31:0] d; logic [1:0] wr;
		logic [11:0] ra; logic [31:0] q; logic [1:0] rr;
	} row_t;
	logic clk, nrst, awvalid, wvalid, bready, arvalid, rready, lvl_we, fail;
	logic awready, wready, bvalid, arready, rvalid, ext_wr, ext_err;
	logic cmd_stb, ext_rd, ext_alias;
	int ext_rds = 0;
	int cmds = 0;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, ctrl, ext_wdata, ext_rdata, q;
	logic [1:0] bresp, rresp, r;
	logic [3:0] wstrb;
	logic [7:0] lvl, evt_set, evt;
	logic [15:0] stat, cmd, wo;
	logic [5:0] ext_idx;
	int err_total, checked;
	row_t rows [15] = '{
		'{1, 12'h000, 32'h3c5a, 0, 12'h000, 32'h3c5a, 0},
		'{1, 12'h004, 32'hffffff11, 0, 12'h004, 32'h11, 0},
		'{0, 12'h000, 0, 0, 12'h000, 32'h3c11, 0},
		'{1, 12'h010, 32'h1234, 0, 12'h010, 32'h5a5a, 0},
		'{1, 12'h014, 32'hbeef, 0, 12'h014, 32'h5a5a, 0},
		'{1, 12'h10c, 32'hcafe0001, 0, 12'h10c, 32'hcafe0001, 0},
		'{0, 12'h20c, 0, 0, 12'h20c, 32'hcafe0001, 0},
		'{1, 12'h20c, 32'habcd, 0, 12'h10c, 32'habcd, 0},
		'{1, 12'h300, 32'h1, 2, 12'h300, 0, 2},
		'{0, 12'h00c, 0, 0, 12'h00c, 32'h0f, 0},
		'{0, 12'h008, 0, 0, 12'h008, 0, 0},
		'{1, 12'h00c, 32'hf0, 0, 12'h008, 32'hf0, 0},
		'{1, 12'h008, 32'h30, 0, 12'h00c, 32'hc0, 0},
		'{0, 12'h008, 0, 0, 12'h008, 0, 0},
		'{1, 12'h000, 32'h3c5a, 0, 12'h004, 32'h5a, 0}};
	regbank_top u_dut (.REF_CLK_I(clk), .NRST_I(nrst), .AWADDR_I(awaddr),
		.AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
		.WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
		.BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
		.RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
		.CTRL_O(ctrl), .LVL_HW_WE_I(lvl_we), .LVL_HW_I(lvl), .EVT_SET_I(evt_set),
		.EVT_O(evt), .STAT_I(stat), .CMD_O(cmd), .CMD_STB_O(cmd_stb), .WO_FIELD_O(wo),
		.EXT_WR_O(ext_wr), .EXT_RD_O(ext_rd), .EXT_IDX_O(ext_idx), .EXT_WDATA_O(ext_wdata),
		.EXT_ALIAS_O(ext_alias), .EXT_RDATA_I(ext_rdata), .EXT_ERR_I(ext_err));
	ext_reg_model u_ext (.clk_i(clk), .wr_i(ext_wr), .idx_i(ext_idx),
		.wdata_i(ext_wdata), .fail_i(fail), .rdata_o(ext_rdata), .err_o(ext_err));
	// Free-running clock
	always #5 clk = ~clk;
	// Count one-cycle strobes toward the far side
	always @(posedge clk) begin
		if (ext_rd) ext_rds <= ext_rds + 1;
		if (cmd_stb) cmds <= cmds + 1;
	end
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Verdict and end of run
	task automatic results();
		$display("mismatches %0d of %0d checks", err_total, checked);
		if (err_total == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Bus write, address and data offered together
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 0;
			if (wvalid && wready) wvalid <= 0;
			if (bvalid) begin
				rs = bresp;
				bready <= 0;
				break;
			end
		end
		if (n == 50) begin
			err_total++;
			results();
		end
	endtask
	// Bus read
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 0;
			if (rvalid) begin
				d = rdata;
				rs = rresp;
				rready <= 0;
				break;
			end
		end
		if (n == 50) begin
			err_total++;
			results();
		end
	endtask
	// Main sequence
	initial begin
		{clk, nrst, awvalid, wvalid, bready, arvalid, rready, lvl_we, fail} = 0;
		{awaddr, araddr, wdata, lvl, evt_set} = 0;
		wstrb = 4'hf;
		stat = 16'h5a5a;
		err_total = 0;
		checked = 0;
		repeat (12) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		evt_set <= 8'h0f;
		@(posedge clk);
		evt_set <= 8'h00;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d, r);
				chk("bresp", r, rows[i].wr);
			end
			rd(rows[i].ra, q, r);
			chk("rdata", q, rows[i].q);
			chk("rresp", r, rows[i].rr);
		end
		chk("command", cmd, 32'h1234);
		chk("write-only", wo, 32'hbeef);
		chk("control", ctrl, 32'h3c5a);
		@(posedge clk);
		lvl <= 8'h77;
		lvl_we <= 1;
		@(posedge clk);
		lvl_we <= 0;
		@(posedge clk);
		chk("level", ctrl, 32'h775a);
		fail <= 1;
		rd(12'h110, q, r);
		chk("ext error", r, 2'b10);
		fail <= 0;
		rd(12'h20c, q, r);
		chk("ext alias data", q, 32'habcd);
		chk("ext alias flag", ext_alias, 1);
		chk("ext reads", ext_rds, 5);
		chk("cmd strobes", cmds, 1);
		evt_set <= 8'h01;
		wr(12'h008, 32'h000000ff, r);
		evt_set <= 8'h00;
		rd(12'h008, q, r);
		chk("set beats clear", q, 32'h01);
		nrst <= 0;
		repeat (2) @(posedge clk);
		chk("ctrl reset", ctrl, 0);
		chk("evt reset", evt, 0);
		nrst <= 1;
		rd(12'h000, q, r);
		chk("after reset", q, 0);
		results();
	end
endmodule
`default_nettype wire
